// ---- device_reset_sequencer_tb.sv ----
// Self-checking bench for the reset sequencer.
// Assumes drs_board supplies hardware reset and a 4-period interface clock.
`timescale 1ns/100ps
module device_reset_sequencer_tb;
  localparam int E_P = 4;
  logic        clk = 1'b0;
  logic        rst, reset_req, hw_reset_n, memif_clock_input, pci_side_reset_n, hold_in;
  logic [3:0]  addr_bits;
  logic        byte_ord, ee_ai, hd5, sp2, emu, pci_en;
  logic        core_reset, pci_sm_reset, z_group_oe_n, eeprom_serial_chip_select_valid;
  logic        eeprom_clk_data_oe_n, memif_z_oe_n, memif_clock_output_one_oe_n, memif_resync;
  logic        memif_high_valid, memif_low_valid;
  logic        bus_hold_acknowledge_valid, bus_request_out_valid;
  logic [6:0]  boot_config;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] d;
  int          miscompares, n_tests, cyc;

  always #25 clk = ~clk;

  drs_board BOARD (.clk, .reset_req, .hw_reset_n, .memif_clock_input);

  drs_top DUT (
    .clk, .rst, .ce(1'b1), .hw_reset_n, .pci_side_reset_n, .emu_reset_req(emu),
    .memif_clock_input, .memif_address_boot_bits(addr_bits), .byte_order_strap(byte_ord),
    .pci_eeprom_autoinit_strap(ee_ai), .host_data_bit5_strap(hd5),
    // enable strap moved only under held reset
    .pci_enable_strap(pci_en), .serial_port2_enable_strap(sp2), .hold_in,
    .core_reset, .pci_sm_reset, .boot_config, .z_group_oe_n,
    .eeprom_serial_chip_select_valid, .eeprom_clk_data_oe_n, .memif_z_oe_n,
    .memif_clock_output_one_oe_n, .memif_high_valid, .memif_low_valid,
    .bus_hold_acknowledge_valid, .bus_request_out_valid, .memif_resync,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 15000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic axi_write(input logic [31:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Release windows measured from the cycle after release, shifted by off_lo/off_hi
  task automatic seq_check(input int off_lo, input int off_hi, input logic ee_mode);
    int t_z, t_low, t_mem, t_rs;
    logic saw_rst;
    t_z = 0;
    t_low = 0;
    t_mem = 0;
    t_rs = 0;
    saw_rst = (core_reset === 1'b1);
    for (int i = 1; i <= 140; i++) begin
      @(posedge clk);
      hold_in <= ~hold_in;
      #1;
      if (core_reset === 1'b1) saw_rst = 1'b1;
      if (t_z == 0 && z_group_oe_n === 1'b0) t_z = i;
      if (t_low == 0 && eeprom_serial_chip_select_valid === 1'b1) t_low = i;
      if (t_mem == 0 && memif_z_oe_n === 1'b0) t_mem = i;
      if (t_rs == 0 && memif_resync === 1'b1) t_rs = i;
      check1(eeprom_clk_data_oe_n, ee_mode ? !eeprom_serial_chip_select_valid : z_group_oe_n);
      check1(memif_clock_output_one_oe_n, memif_z_oe_n);
      check1(memif_high_valid, !memif_z_oe_n);
      check1(bus_request_out_valid, memif_low_valid);
    end
    check1(saw_rst, 1'b1);
    check1(t_z >= 2 + off_lo && t_z <= 8 + off_hi, 1'b1);
    check1(t_low >= 1 && t_low <= 11 + off_hi, 1'b1);
    check1(t_mem >= 16 * E_P + off_lo && t_mem <= 8 + 20 * E_P + off_hi, 1'b1);
    check1(t_rs >= 2 * E_P + off_lo && t_rs <= 8 + 20 * E_P + off_hi, 1'b1);
    check1(core_reset, 1'b0);
    check1(bus_hold_acknowledge_valid, 1'b1);
  endtask

  task automatic t_hw_boot();
    @(posedge clk);
    reset_req <= 1'b0;
    @(posedge hw_reset_n);
    seq_check(0, 0, 1'b1);
    check({25'h0, boot_config}, 32'h55);
    axi_read(32'h8);
    check(d, 32'h155);
    axi_read(32'h4);
    check({28'h0, d[3:0]}, 32'h8);
    $display("test hw_boot done");
  endtask

  task automatic t_bus();
    axi_read(32'hC);
    check({30'h0, r}, {30'h0, drs_pkg::RESP_SLVERR});
    axi_write(32'hC, 32'h3);
    check({30'h0, r}, {30'h0, drs_pkg::RESP_SLVERR});
    check1(core_reset, 1'b0);
    axi_write(32'h4, 32'h0);
    check({30'h0, r}, {30'h0, drs_pkg::RESP_OKAY});
    axi_read(32'h0);
    check(d, 32'h0);
    $display("test bus done");
  endtask

  // Straps moved away first, so a relatch would show
  task automatic t_warm(input logic [31:0] v);
    addr_bits <= 4'h3;
    byte_ord <= 1'b0;
    ee_ai <= 1'b1;
    hd5 <= 1'b0;
    axi_write(32'h0, v);
    check({30'h0, r}, {30'h0, drs_pkg::RESP_OKAY});
    seq_check(14, 14, 1'b1);
    check({25'h0, boot_config}, 32'h55);
    $display("test warm %0d done", v);
  endtask

  task automatic t_pci_hw();
    @(posedge clk);
    pci_side_reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check1(pci_sm_reset, 1'b1);
    check1(core_reset, 1'b0);
    check1(z_group_oe_n, 1'b0);
    @(posedge clk);
    pci_side_reset_n <= 1'b1;
    reset_req <= 1'b1;
    sp2 <= 1'b1;
    addr_bits <= 4'hC;
    byte_ord <= 1'b1;
    ee_ai <= 1'b1;
    hd5 <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check1(z_group_oe_n, 1'b1);
    check1(eeprom_serial_chip_select_valid, 1'b0);
    repeat (15) @(posedge clk);
    #1;
    check1(memif_z_oe_n, 1'b1);
    check1(memif_clock_output_one_oe_n, 1'b1);
    check1(memif_high_valid | memif_low_valid, 1'b0);
    check1(pci_sm_reset, 1'b0);
    @(posedge clk);
    reset_req <= 1'b0;
    pci_en <= 1'b0;
    @(posedge hw_reset_n);
    seq_check(0, 0, 1'b0);
    check({25'h0, boot_config}, 32'h66);
    axi_read(32'h8);
    check(d, 32'h266);
    axi_write(32'h0, 32'h1);
    check({30'h0, r}, {30'h0, drs_pkg::RESP_OKAY});
    check1(core_reset, 1'b0);
    @(posedge clk);
    emu <= 1'b1;
    @(posedge clk);
    emu <= 1'b0;
    @(posedge clk);
    #1;
    check1(core_reset, 1'b1);
    check({25'h0, boot_config}, 32'h66);
    $display("test pci_hw done");
  endtask

  initial begin
    rst = 1'b1;
    reset_req = 1'b1;
    pci_side_reset_n = 1'b1;
    hold_in = 1'b0;
    addr_bits = 4'hA;
    byte_ord = 1'b1;
    ee_ai = 1'b0;
    hd5 = 1'b1;
    sp2 = 1'b0;
    emu = 1'b0;
    pci_en = 1'b1;
    s_axi_awaddr = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_hw_boot();
    t_bus();
    t_warm(32'h1);
    t_warm(32'h2);
    t_pci_hw();
    give_verdict();
  end
endmodule

// ---- drs_board.sv ----
// Board-side model: hardware reset source and memory-interface clock.
// Assumes reset_req changes on clk edges; clocks run before any release.
`timescale 1ns/100ps
module drs_board #(
  parameter real E_HALF_NS = 100.0
) (
  input  wire logic clk,
  input  wire logic reset_req,
  output logic      hw_reset_n,
  output logic      memif_clock_input
);
  int low_cnt;

  initial begin
    hw_reset_n = 1'b0;
    low_cnt = 0;
  end

  // low for the full minimum width, released on a clock edge
  always @(posedge clk) begin
    if (reset_req && hw_reset_n) begin
      hw_reset_n <= 1'b0;
      low_cnt <= 0;
    end else if (!hw_reset_n) begin
      low_cnt <= low_cnt + 1;
      if (!reset_req && low_cnt >= drs_pkg::HW_RESET_MIN_CYC) hw_reset_n <= 1'b1;
    end
  end

  // free-running interface clock, phase unrelated to clk
  initial begin
    memif_clock_input = 1'b0;
    #37;
    forever #(E_HALF_NS) memif_clock_input = ~memif_clock_input;
  end
endmodule

// ---- drs_pkg.sv ----
// Constants and types for the device reset sequencer.
// Assumes a 20 MHz CPU clock and a synchronously sampled memory-interface clock.
package drs_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // Hardware reset low time expected from the board
  localparam int HW_RESET_MIN_US  = 250;
  localparam int HW_RESET_MIN_CYC = (HW_RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Release points in CPU periods after reset release
  localparam logic [3:0] Z_MIN_P    = 4'h2;
  localparam logic [3:0] Z_MAX_P    = 4'h8;
  localparam logic [3:0] Z_REL_P    = 4'h4;
  localparam logic [3:0] LOW_MAX_P  = 4'hB;
  localparam logic [3:0] LOW_REL_P  = 4'h6;
  // Release points in memory-interface periods after reset release
  localparam logic [4:0] RESYNC_E   = 5'h03;
  localparam logic [4:0] MEM_MIN_E  = 5'h10;
  localparam logic [4:0] MEM_REL_E  = 5'h11;
  localparam logic [4:0] MEM_MAX_E  = 5'h14;
  // Length of an internal soft or emulation reset, CPU periods
  localparam logic [4:0] SOFT_HOLD_P = 5'h10;
  // Register byte offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_BOOT   = 4'h8;
  // Control bit positions
  localparam int CTRL_SOFT_BIT = 0;
  localparam int CTRL_EMU_BIT  = 1;
  // Boot register layout
  localparam int BOOT_PCI_BIT  = 8;
  localparam int BOOT_SP2_BIT  = 9;
  // Bus answers and the boot configuration reset value
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [6:0] BOOT_RESET  = 7'h00;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_SOFT = 4'h2,
    ST_SEQ  = 4'h4,
    ST_RUN  = 4'h8
  } drs_state_t;

  typedef struct packed {
    drs_state_t  state;
    logic [3:0]  p_cnt;
    logic [4:0]  e_cnt;
    logic [4:0]  soft_cnt;
    logic        mclk_q;
    logic [6:0]  boot_cfg;
    logic        pci_en_boot;
    logic        sp2_boot;
    logic        core_reset;
    logic        z_oe_n;
    logic        low_valid;
    logic        ee_cs_valid;
    logic        ee_cd_oe_n;
    logic        mem_z_oe_n;
    logic        mclk_out_oe_n;
    logic        mem_hi_valid;
    logic        mem_lo_valid;
    logic        hold_ack_valid;
    logic        bus_req_valid;
    logic        resync;
    logic        pci_sm_reset;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic [3:0]  awaddr;
    logic [1:0]  wbits;
    logic        wstrb0;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } drs_regs_t;
endpackage

// ---- drs_top.sv ----
// Device reset sequencer: reset sources, boot strap capture, pin-group release.
// Assumes all pins synchronous to clk; memory-interface clock is sampled as data.
//
// Contract
// - Soft reset accepted only with PCI enabled.
// - Soft reset keeps last latched boot configuration.
// - Hardware reset leaves PCI state machine alone.
// - PCI-side reset resets only PCI machine.
// - Emulation reset behaves like soft reset, but is not gated by PCI enable.
// - Straps captured at hardware reset rising edge.
// - Z group floats, drives 2..8 P later.
// - EEPROM low group valid within 11 P.
// - EEPROM low group only when PCI, not port2; chip select still goes valid in every mode.
// - Memory Z floats, valid 16E..8P+20E after.
// - Memory clock resync 2E..8P+20E after release.
// - Memory clock output floats, valid by 8P+20E.
// - Memory high/low groups invalid, then valid.
// - Hold acknowledge group follows hold input level.
`timescale 1ns/100ps
module drs_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        hw_reset_n,
  input  wire logic        pci_side_reset_n,
  input  wire logic        emu_reset_req,
  input  wire logic        memif_clock_input,
  input  wire logic [3:0]  memif_address_boot_bits,
  input  wire logic        byte_order_strap,
  input  wire logic        pci_eeprom_autoinit_strap,
  input  wire logic        host_data_bit5_strap,
  input  wire logic        pci_enable_strap,
  input  wire logic        serial_port2_enable_strap,
  input  wire logic        hold_in,
  output logic             core_reset,
  output logic             pci_sm_reset,
  output logic [6:0]       boot_config,
  output logic             z_group_oe_n,
  output logic             eeprom_serial_chip_select_valid,
  output logic             eeprom_clk_data_oe_n,
  output logic             memif_z_oe_n,
  output logic             memif_clock_output_one_oe_n,
  output logic             memif_high_valid,
  output logic             memif_low_valid,
  output logic             bus_hold_acknowledge_valid,
  output logic             bus_request_out_valid,
  output logic             memif_resync,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  drs_pkg::drs_regs_t s_reg;
  drs_pkg::drs_regs_t s_next;

  logic       mclk_rise;
  logic       in_reset;
  logic       wr_go;
  logic       soft_go;
  logic       low_mode;
  logic [6:0] strap_now;

  assign mclk_rise = memif_clock_input & ~s_reg.mclk_q;
  assign strap_now = {memif_address_boot_bits, byte_order_strap,
                      pci_eeprom_autoinit_strap, host_data_bit5_strap};
  assign wr_go = ~s_reg.awready & ~s_reg.wready & ~s_reg.bvalid;

  always_comb begin
    s_next  = s_reg;
    soft_go = 1'b0;
    s_next.mclk_q = memif_clock_input;
    // PCI-side reset drives only the PCI machine
    s_next.pci_sm_reset = ~pci_side_reset_n;

    // AXI write: address and data taken in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.awready = 1'b0;
      s_next.awaddr  = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.wready = 1'b0;
      s_next.wbits  = s_axi_wdata[1:0];
      s_next.wstrb0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      s_next.bvalid = 1'b1;
      if (s_reg.awaddr == drs_pkg::OFF_CTRL) begin
        s_next.bresp = drs_pkg::RESP_OKAY;
        // host soft reset gated by PCI enable
        // emulation request shares the soft path
        soft_go = s_reg.wstrb0 &
                  ((s_reg.wbits[drs_pkg::CTRL_SOFT_BIT] & s_reg.pci_en_boot) |
                   s_reg.wbits[drs_pkg::CTRL_EMU_BIT]);
      end else if (s_reg.awaddr == drs_pkg::OFF_STATUS ||
                   s_reg.awaddr == drs_pkg::OFF_BOOT) begin
        s_next.bresp = drs_pkg::RESP_OKAY;
      end else begin
        s_next.bresp = drs_pkg::RESP_SLVERR;
      end
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid  = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready  = 1'b1;
    end

    // AXI read
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid  = 1'b1;
      s_next.rresp   = drs_pkg::RESP_OKAY;
      case (s_axi_araddr[3:0])
        drs_pkg::OFF_CTRL: begin
          s_next.rdata = 32'h0000_0000;
        end
        drs_pkg::OFF_STATUS: begin
          s_next.rdata = {16'h0000, 3'h0, s_reg.e_cnt, s_reg.p_cnt, s_reg.state};
        end
        drs_pkg::OFF_BOOT: begin
          s_next.rdata = {22'h00_0000, s_reg.sp2_boot, s_reg.pci_en_boot, 1'b0,
                          s_reg.boot_cfg};
        end
        default: begin
          s_next.rdata = 32'h0000_0000;
          s_next.rresp = drs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid  = 1'b0;
      s_next.arready = 1'b1;
    end

    // Reset sequencing
    // hardware reset never touches the PCI machine
    case (s_reg.state)
      drs_pkg::ST_HOLD: begin
        if (hw_reset_n) begin
          s_next.boot_cfg    = strap_now;
          s_next.pci_en_boot = pci_enable_strap;
          s_next.sp2_boot    = serial_port2_enable_strap;
          s_next.state       = drs_pkg::ST_SEQ;
          s_next.p_cnt       = 4'h0;
          s_next.e_cnt       = 5'h00;
        end
      end
      drs_pkg::ST_SOFT: begin
        // boot configuration kept through soft reset
        if (s_reg.soft_cnt == drs_pkg::SOFT_HOLD_P - 5'h01) begin
          s_next.state = drs_pkg::ST_SEQ;
          s_next.p_cnt = 4'h0;
          s_next.e_cnt = 5'h00;
        end else begin
          s_next.soft_cnt = s_reg.soft_cnt + 5'h01;
        end
      end
      drs_pkg::ST_SEQ: begin
        if (s_reg.p_cnt != 4'hF) begin
          s_next.p_cnt = s_reg.p_cnt + 4'h1;
        end
        if (mclk_rise && s_reg.e_cnt != 5'h1F) begin
          s_next.e_cnt = s_reg.e_cnt + 5'h01;
        end
        if (s_reg.e_cnt >= drs_pkg::MEM_REL_E && s_reg.p_cnt >= drs_pkg::LOW_REL_P) begin
          s_next.state = drs_pkg::ST_RUN;
        end
      end
      drs_pkg::ST_RUN: begin
      end
      default: begin
        s_next.state = drs_pkg::ST_HOLD;
      end
    endcase
    // emulation pin restarts the soft hold
    if ((soft_go || emu_reset_req) && s_reg.state != drs_pkg::ST_HOLD) begin
      s_next.state    = drs_pkg::ST_SOFT;
      s_next.soft_cnt = 5'h00;
    end
    if (!hw_reset_n) begin
      s_next.state = drs_pkg::ST_HOLD;
    end

    in_reset = ~hw_reset_n | (s_next.state == drs_pkg::ST_HOLD) |
               (s_next.state == drs_pkg::ST_SOFT);
    low_mode = s_reg.pci_en_boot & ~s_reg.sp2_boot;
    s_next.core_reset = in_reset;
    // Z group released at fixed P count
    s_next.z_oe_n = in_reset | ~(s_reg.state == drs_pkg::ST_RUN ||
                                 (s_reg.state == drs_pkg::ST_SEQ &&
                                  s_reg.p_cnt >= drs_pkg::Z_REL_P));
    // EEPROM low group valid after fixed P count
    s_next.low_valid = ~in_reset & (s_reg.state == drs_pkg::ST_RUN ||
                                    (s_reg.state == drs_pkg::ST_SEQ &&
                                     s_reg.p_cnt >= drs_pkg::LOW_REL_P));
    s_next.ee_cs_valid = s_next.low_valid;
    s_next.ee_cd_oe_n  = low_mode ? ~s_next.low_valid : s_next.z_oe_n;
    s_next.mem_z_oe_n    = in_reset | ~(s_reg.state == drs_pkg::ST_RUN ||
                                        (s_reg.state == drs_pkg::ST_SEQ &&
                                         s_reg.e_cnt >= drs_pkg::MEM_REL_E));
    s_next.mclk_out_oe_n = s_next.mem_z_oe_n;
    s_next.mem_hi_valid  = ~s_next.mem_z_oe_n;
    s_next.mem_lo_valid  = ~s_next.mem_z_oe_n;
    s_next.hold_ack_valid = hold_in ? s_next.mem_hi_valid : s_next.mem_lo_valid;
    s_next.bus_req_valid  = s_next.mem_lo_valid;
    s_next.resync = ~in_reset & (s_reg.state == drs_pkg::ST_SEQ) & mclk_rise &
                    (s_reg.e_cnt == drs_pkg::RESYNC_E - 5'h01);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.state <= drs_pkg::ST_HOLD;
      s_reg.boot_cfg <= drs_pkg::BOOT_RESET;
      s_reg.core_reset <= 1'b1;
      s_reg.z_oe_n <= 1'b1;
      s_reg.ee_cd_oe_n <= 1'b1;
      s_reg.mem_z_oe_n <= 1'b1;
      s_reg.mclk_out_oe_n <= 1'b1;
      s_reg.pci_sm_reset <= 1'b1;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign core_reset                      = s_reg.core_reset;
  assign pci_sm_reset                    = s_reg.pci_sm_reset;
  assign boot_config                     = s_reg.boot_cfg;
  assign z_group_oe_n                    = s_reg.z_oe_n;
  assign eeprom_serial_chip_select_valid = s_reg.ee_cs_valid;
  assign eeprom_clk_data_oe_n            = s_reg.ee_cd_oe_n;
  assign memif_z_oe_n                    = s_reg.mem_z_oe_n;
  assign memif_clock_output_one_oe_n     = s_reg.mclk_out_oe_n;
  assign memif_high_valid                = s_reg.mem_hi_valid;
  assign memif_low_valid                 = s_reg.mem_lo_valid;
  assign bus_hold_acknowledge_valid      = s_reg.hold_ack_valid;
  assign bus_request_out_valid           = s_reg.bus_req_valid;
  assign memif_resync                    = s_reg.resync;
  assign s_axi_awready                   = s_reg.awready;
  assign s_axi_wready                    = s_reg.wready;
  assign s_axi_bresp                     = s_reg.bresp;
  assign s_axi_bvalid                    = s_reg.bvalid;
  assign s_axi_arready                   = s_reg.arready;
  assign s_axi_rdata                     = s_reg.rdata;
  assign s_axi_rresp                     = s_reg.rresp;
  assign s_axi_rvalid                    = s_reg.rvalid;

  // Cycles since entering release sequence, for checks
  logic [4:0] rel_cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      rel_cnt <= 5'h00;
    end else if (ce) begin
      if (s_reg.state != drs_pkg::ST_SEQ && s_next.state == drs_pkg::ST_SEQ) begin
        rel_cnt <= 5'h00;
      end else if (rel_cnt != 5'h1F) begin
        rel_cnt <= rel_cnt + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_release;
    ce && s_reg.state == drs_pkg::ST_HOLD && hw_reset_n;
  endsequence
  sequence s_hw_low;
    ce && !hw_reset_n;
  endsequence

  a_strap_capture: assert property (s_release |=> boot_config == $past(strap_now))
    else $error("Straps not captured at release");
  a_z_float: assert property (s_hw_low |=> z_group_oe_n)
    else $error("Z group driven in reset");
  a_z_window: assert property ($fell(z_group_oe_n) |-> rel_cnt >= 5'h02 && rel_cnt <= 5'h08)
    else $error("Z group release outside window");
  a_low_bound: assert property ($rose(eeprom_serial_chip_select_valid) |-> rel_cnt <= 5'h0B)
    else $error("EEPROM low group late");
  a_mem_float: assert property (s_hw_low |=> memif_z_oe_n && memif_clock_output_one_oe_n)
    else $error("Memory pins driven in reset");
  a_mem_valid: assert property ($fell(memif_z_oe_n) |-> s_reg.e_cnt >= 5'h10)
    else $error("Memory Z group released early");
  a_resync_min: assert property ($rose(memif_resync) |-> s_reg.e_cnt >= 5'h02)
    else $error("Resync before two memory periods");
  a_grp_invalid: assert property (s_hw_low |=> !memif_high_valid && !memif_low_valid)
    else $error("Memory groups valid in reset");
  a_pci_keep: assert property ((s_hw_low and pci_side_reset_n) |=> !pci_sm_reset)
    else $error("Hardware reset hit PCI machine");
  a_soft_keep: assert property (ce && s_reg.state == drs_pkg::ST_SOFT |=>
                                $stable(boot_config))
    else $error("Soft reset changed boot configuration");
  a_soft_gate: assert property (ce && wr_go && s_reg.awaddr == drs_pkg::OFF_CTRL &&
                                s_reg.wbits == 2'b01 && !s_reg.pci_en_boot &&
                                s_reg.state == drs_pkg::ST_RUN && hw_reset_n && !emu_reset_req
                                |=> s_reg.state == drs_pkg::ST_RUN)
    else $error("Soft reset taken with PCI disabled");
  a_hold_map: assert property (ce ##1 ce |-> bus_hold_acknowledge_valid ==
                               ($past(hold_in) ? memif_high_valid : memif_low_valid))
    else $error("Hold acknowledge group wrong");
endmodule
